// File: src/papcp_defines.vh
// Overview of operation
// R1 - In both parallel schemes the host sends one byte at a time and the device reads all eight data lines; the code captures only in the async scheme.
// R2 - In a serial scheme the device leaves data lines one to seven undriven throughout configuration.
// R3 - After parallel configuration ends, data lines one to seven follow the user-mode shared-pin setting.
// R4 - In the async parallel scheme data line seven takes bit seven on writes and carries status on reads.
// R5 - While the read strobe is low the device drives ready/busy onto data line seven.
// R6 - Each rising edge of the write strobe captures the byte on the data lines.
// R7 - Ready/busy is high when another byte can be taken and low while busy.
// R8 - Ready/busy is driven high after power-up before configuration and after it before user mode.
// R9 - Outside the async parallel scheme the read strobe, write strobe and ready/busy pins stay undriven.
// R10 - A host that does not use the read strobe should tie it high.
// R11 - After async parallel configuration, line seven, both strobes and ready/busy follow the user-mode setting.
// R12 - The host selects the device with select low and select high, held through configuration.
// R13 - The host waits for ready before the next write strobe rising edge.
`ifndef PAPCP_DEFINES_VH
`define PAPCP_DEFINES_VH
`define PAPCP_SCHEME_SERIAL  2'h0
`define PAPCP_SCHEME_FAST    2'h1
`define PAPCP_SCHEME_ASYNC   2'h2
`define PAPCP_BYTE_W         8
`define PAPCP_FIFO_DEPTH     16
`define PAPCP_BUSY_CYCLES    4
`define PAPCP_STATUS_BIT     7
`endif

// File: src/papcp_fifo.v
`timescale 1ns/100ps
module papcp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @* begin
        out_data = mem[rd_ptr_reg];
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: src/papcp_port.v
`timescale 1ns/100ps
`include "papcp_defines.vh"
module papcp_port #(
    parameter BUSY_CYCLES = `PAPCP_BUSY_CYCLES,
    parameter FIFO_DEPTH  = `PAPCP_FIFO_DEPTH
) (
    // clock and reset
    input  wire       CLK,
    input  wire       RST,
    // scheme and phase
    input  wire [1:0] SCHEME,
    input  wire       CONFIG_ACTIVE,
    input  wire       USER_MODE,
    // user-mode shared-pin control
    input  wire [7:0] USER_DATA_OUT,
    input  wire [7:0] USER_DATA_OE,
    input  wire       USER_READY_OUT,
    input  wire       USER_READY_OE,
    // pins
    input  wire [7:0] DATA_IN,
    output wire [7:0] DATA_OUT,
    output wire [7:0] DATA_OE,
    input  wire       WRITE_STROBE_LOW,
    input  wire       READ_STROBE_LOW,
    output wire       READY_NOT_BUSY,
    output wire       READY_NOT_BUSY_OE,
    // configuration byte stream
    output wire       CFG_VALID,
    input  wire       CFG_READY,
    output wire [7:0] CFG_BYTE
);
    reg  [7:0] data_s1_reg;
    reg  [7:0] data_s2_reg;
    reg  [2:0] ws_s_reg;
    reg  [1:0] rs_s_reg;
    reg  [7:0] hold_reg;
    reg        push_reg;
    reg  [7:0] busy_cnt_reg;
    wire       async_sel;
    wire       cfg_sel;
    wire       ws_rise;
    wire       fifo_in_ready;
    wire       ready;
    wire       status_drv;

    assign async_sel = (SCHEME == `PAPCP_SCHEME_ASYNC);
    assign cfg_sel   = !USER_MODE;

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            data_s1_reg <= 8'h00;
            data_s2_reg <= 8'h00;
            ws_s_reg    <= 3'h7;
            rs_s_reg    <= 2'h3;
        end else begin
            data_s1_reg <= DATA_IN;
            data_s2_reg <= data_s1_reg;
            ws_s_reg    <= {ws_s_reg[1:0], WRITE_STROBE_LOW};
            rs_s_reg    <= {rs_s_reg[0], READ_STROBE_LOW};
        end
    end

    // edge is taken between stages two and three, never from stage one
    assign ws_rise = ws_s_reg[2] == 1'b0 && ws_s_reg[1] == 1'b1;

    // hold time: data stays valid across the strobe rise, so the synced bus is used
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            hold_reg     <= 8'h00;
            push_reg     <= 1'b0;
            busy_cnt_reg <= 8'h00;
        end else begin
            if (ws_rise && async_sel && CONFIG_ACTIVE && cfg_sel) begin
                hold_reg     <= data_s2_reg; // R6 R1
                push_reg     <= 1'b1;
                busy_cnt_reg <= BUSY_CYCLES[7:0];
            end else begin
                if (push_reg && fifo_in_ready) begin
                    push_reg <= 1'b0;
                end
                if (busy_cnt_reg != 8'h00) begin
                    busy_cnt_reg <= busy_cnt_reg - 8'h01;
                end
            end
        end
    end

    papcp_fifo #(
        .WIDTH (`PAPCP_BYTE_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (CLK),
        .rst       (RST),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (hold_reg),
        .out_valid (CFG_VALID),
        .out_ready (CFG_READY),
        .out_data  (CFG_BYTE)
    );

    // busy during configuration while a byte is pending, the busy count runs or the buffer cannot take another
    assign ready = !push_reg && fifo_in_ready && busy_cnt_reg == 8'h00 || !CONFIG_ACTIVE; // R7 R8

    assign status_drv = cfg_sel && async_sel && rs_s_reg[1] == 1'b0; // R4 R5

    // during configuration only line seven may drive; serial keeps all undriven
    assign DATA_OUT = USER_MODE ? USER_DATA_OUT : {ready, 7'h00}; // R3 R11
    assign DATA_OE  = USER_MODE ? USER_DATA_OE  : {status_drv, 7'h00}; // R2 R9

    assign READY_NOT_BUSY    = USER_MODE ? USER_READY_OUT : ready; // R8 R11
    assign READY_NOT_BUSY_OE = USER_MODE ? USER_READY_OE  : async_sel; // R9
endmodule

// File: sim/papcp_checker.sv
`timescale 1ns/100ps
module papcp_checker (
    // watched ports
    input       CLK,
    input       RST,
    input [1:0] SCHEME,
    input       CONFIG_ACTIVE,
    input       USER_MODE,
    input [7:0] USER_DATA_OE,
    input       USER_READY_OE,
    input       READ_STROBE_LOW,
    input       WRITE_STROBE_LOW,
    input [7:0] DATA_OUT,
    input [7:0] DATA_OE,
    input       READY_NOT_BUSY,
    input       READY_NOT_BUSY_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // the read strobe passes two sync flops and the write strobe three, so waits allow that lag
    wire c = SCHEME == 2'h2 && CONFIG_ACTIVE && !USER_MODE;
    sequence rd_low; (c && !READ_STROBE_LOW)[*3]; endsequence
    sequence wr_rise; c && $rose(WRITE_STROBE_LOW); endsequence
    a_user_oe_pass: assert property (USER_MODE |-> DATA_OE == USER_DATA_OE) else $error("oe");
    a_user_rdy_pass: assert property (USER_MODE |-> READY_NOT_BUSY_OE == USER_READY_OE)
        else $error("rdy oe");
    a_low_lines_in: assert property (!USER_MODE |-> DATA_OE[6:0] == 7'h00) else $error("d oe");
    a_pins_stay_off: assert property (!USER_MODE && SCHEME != 2'h2 |-> !READY_NOT_BUSY_OE)
        else $error("off");
    a_idle_rdy_high: assert property (SCHEME == 2'h2 && !CONFIG_ACTIVE && !USER_MODE
        |-> READY_NOT_BUSY && READY_NOT_BUSY_OE) else $error("idle");
    a_read_gives_bit: assert property (rd_low |-> DATA_OE[7] && DATA_OUT[7] == READY_NOT_BUSY)
        else $error("rd");
    a_write_bit_in: assert property ((c && READ_STROBE_LOW)[*3] |-> !DATA_OE[7]) else $error("w");
    a_write_goes_busy: assert property (wr_rise |-> ##[1:6] !READY_NOT_BUSY) else $error("b");
endmodule
bind papcp_port papcp_checker chk (.*);

// File: sim/papcp_host.sv
`timescale 1ns/100ps
module papcp_host (
    // pins
    input              clk,
    input              st,
    input              st_oe,
    output logic       ws_n,
    output logic       rs_n,
    output logic [7:0] d
);
    initial {ws_n, rs_n, d} = 10'h300;
    task automatic wr(input logic [7:0] b, input int gap);
        int n;
        d = b;
        ws_n = 1'b0;
        repeat (gap) @(negedge clk);
        ws_n = 1'b1;
        repeat (4) @(negedge clk);
        // stale data would hide a late capture
        d = ~b;
        rs_n = 1'b0;
        for (n = 0; n < 40 && !(st_oe && st); n++) @(negedge clk);
        rs_n = 1'b1;
        @(negedge clk);
    endtask
endmodule

// File: sim/parallel_async_config_port_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t mismatch", $time); end end
module parallel_async_config_port_test;
    logic       clk = 0, rst = 1, cf = 0, um = 0, cr = 0;
    logic [1:0] sc = 0;
    logic       ur = 0, ure = 1;
    logic [7:0] uo = 0, ue = 0;
    wire        ws, rs, rdy, roe, v;
    wire  [7:0] hd, o, oe, by;
    int         bad_count = 0, n_tests = 0;
    papcp_host host (.clk(clk), .st(o[7]), .st_oe(oe[7]), .ws_n(ws), .rs_n(rs), .d(hd));
    papcp_port #(.BUSY_CYCLES(1)) uut (.CLK(clk), .RST(rst), .SCHEME(sc), .CONFIG_ACTIVE(cf),
        .USER_MODE(um), .USER_DATA_OUT(uo), .USER_DATA_OE(ue), .USER_READY_OUT(ur),
        .USER_READY_OE(ure), .DATA_IN({oe[7] ? o[7] : hd[7], hd[6:0]}), .DATA_OUT(o),
        .DATA_OE(oe), .WRITE_STROBE_LOW(ws), .READ_STROBE_LOW(rs), .READY_NOT_BUSY(rdy),
        .READY_NOT_BUSY_OE(roe), .CFG_VALID(v), .CFG_READY(cr), .CFG_BYTE(by));
    initial forever #2 clk = ~clk;
    initial begin
        #40000;
        bad_count++;
        end_of_test;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_idle;
        for (int s = 0; s < 3; s++) begin
            sc = s[1:0];
            @(negedge clk);
            `CHK({roe, rdy | (s != 2), oe}, {s == 2, 9'h100})
        end
        $display("idle ok");
    endtask
    task automatic t_stream;
        cf = 1;
        for (int i = 0; i < 16; i++) host.wr({i[3:0], ~i[3:0]}, 1 + i % 3);
        `CHK(rdy, 1'b0)
        cr = 1;
        for (int i = 0; i < 16; i++) begin
            for (int n = 0; n < 20 && !v; n++) @(negedge clk);
            `CHK(by, {i[3:0], ~i[3:0]})
            @(negedge clk);
        end
        cr = 0;
        repeat (8) @(negedge clk);
        `CHK(rdy, 1'b1)
        `CHK(v, 1'b0)
        cf = 0;
        $display("stream ok");
    endtask
    task automatic t_user;
        {um, uo, ue, ur, ure} = 19'h70d6a;
        @(negedge clk);
        `CHK({o, oe, rdy, roe}, 18'h30d6a)
        {um, ur, ure} = 3'h1;
        $display("user ok");
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        t_idle;
        t_stream;
        t_user;
        end_of_test;
    end
endmodule
